/* hw/port_c_d_pin_mux.sv */
// Pin multiplexer and direction control for ports C and D
//
// Functional notes
// - Port C has four I/O pins, data at C4, direction at C5.
// - Reset clears the port C direction register; all pins are inputs.
// - Serial mode control at E0 selects the port C serial functions.
// - Bit 6 is serial data out when the mode field low bit is 1.
// - Bit 5 is serial data in when the mode field high bit is 1.
// - Bit 4 drives the serial clock when the mode field is not 00 and clock select is 00, 01, 10.
// - Bit 4 takes the serial clock from outside when the mode field is not 00 and clock select is 11.
// - Bit 3 is ready input when ready enabled and clock is internal.
// - Bit 3 drives ready out when ready enabled and clock is external.
// - Port D has three I/O pins, data at C6, direction at C7.
// - Port D alternate select at CD resets to 0; 1 picks interrupt.
// - A selected interrupt pin ignores its port D direction bit.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Data reads return pin levels; writes only load the latch.
`timescale 1ns/1ps
module port_c_d_pin_mux #(
   parameter int PC_WIDTH = port_c_d_pkg::PC_WIDTH,
   parameter int PD_WIDTH = port_c_d_pkg::PD_WIDTH
) (
   // Clock and reset
   input  wire logic                     sys_clk_i,
   input  wire logic                     resetn_i,
   // Register port
   input  wire port_c_d_pkg::reg_req_s   bus_i,
   output logic [7:0]                    rdata_o,
   // Port C pins
   input  wire logic [PC_WIDTH-1:0]      pc_in_i,
   output logic [PC_WIDTH-1:0]           pc_out_o,
   output logic [PC_WIDTH-1:0]           pc_oe_o,
   // Port D pins
   input  wire logic [PD_WIDTH-1:0]      pd_in_i,
   output logic [PD_WIDTH-1:0]           pd_out_o,
   output logic [PD_WIDTH-1:0]           pd_oe_o,
   // Serial shifter side
   input  wire port_c_d_pkg::ser_drive_s ser_i,
   output port_c_d_pkg::ser_sense_s      ser_o,
   // External interrupt inputs towards the interrupt logic
   output logic [PD_WIDTH-1:0]           ext_int_o
);

   localparam int NPINS  = PC_WIDTH + PD_WIDTH;
   localparam int PC_LSB = port_c_d_pkg::PC_LSB;

   // Register contents
   logic [PC_WIDTH-1:0] port_c_data;
   logic [PC_WIDTH-1:0] port_c_direction;
   logic [PD_WIDTH-1:0] port_d_data;
   logic [PD_WIDTH-1:0] port_d_direction;
   logic [PD_WIDTH-1:0] port_d_alt_select;
   logic [1:0]          clock_select_field;
   logic [1:0]          serial_mode_field;
   logic                ready_enable_bit;

   // Decoded functions
   logic                serial_clock_on;
   logic                clock_external;
   logic [NPINS-1:0]    alt_en;
   logic [NPINS-1:0]    alt_out;
   logic [NPINS-1:0]    alt_oe;
   logic [NPINS-1:0]    gpio_out;
   logic [NPINS-1:0]    gpio_dir;
   logic [NPINS-1:0]    next_pin_out;
   logic [NPINS-1:0]    next_pin_oe;
   logic [7:0]          next_rdata;
   logic [7:0]          serial_mode_ctrl;

   // Register writes
   wire logic wr_c_data = bus_i.wr &&
                          bus_i.addr == port_c_d_pkg::PORT_C_DATA_ADDR;
   wire logic wr_c_dir  = bus_i.wr &&
                          bus_i.addr == port_c_d_pkg::PORT_C_DIRECTION_ADDR;
   wire logic wr_d_data = bus_i.wr &&
                          bus_i.addr == port_c_d_pkg::PORT_D_DATA_ADDR;
   wire logic wr_d_dir  = bus_i.wr &&
                          bus_i.addr == port_c_d_pkg::PORT_D_DIRECTION_ADDR;
   wire logic wr_d_alt  = bus_i.wr &&
                          bus_i.addr == port_c_d_pkg::PORT_D_ALT_SELECT_ADDR;
   wire logic wr_smode  = bus_i.wr &&
                          bus_i.addr == port_c_d_pkg::SERIAL_MODE_CTRL_ADDR;

   // Port C latch and direction
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         port_c_data      <= '0;
         port_c_direction <= '0;
      end else begin
         if (wr_c_data) begin
            port_c_data <= bus_i.wdata[PC_LSB +: PC_WIDTH];
         end
         if (wr_c_dir) begin
            port_c_direction <= bus_i.wdata[PC_LSB +: PC_WIDTH];
         end
      end
   end

   // Port D latch, direction and alternate select
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         port_d_data       <= '0;
         port_d_direction  <= '0;
         port_d_alt_select <= '0;
      end else begin
         if (wr_d_data) begin
            port_d_data <= bus_i.wdata[PD_WIDTH-1:0];
         end
         if (wr_d_dir) begin
            port_d_direction <= bus_i.wdata[PD_WIDTH-1:0];
         end
         if (wr_d_alt) begin
            port_d_alt_select <= bus_i.wdata[PD_WIDTH-1:0];
         end
      end
   end

   // Serial mode control
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clock_select_field <= '0;
         serial_mode_field  <= '0;
         ready_enable_bit   <= 1'b0;
      end else if (wr_smode) begin
         clock_select_field <=
            bus_i.wdata[port_c_d_pkg::SCK_SEL_LSB +: 2];
         serial_mode_field  <= bus_i.wdata[port_c_d_pkg::SM_LSB +: 2];
         ready_enable_bit   <= bus_i.wdata[port_c_d_pkg::READY_EN_BIT];
      end
   end

   always_comb begin
      serial_mode_ctrl = port_c_d_pkg::READ_ZERO;
      serial_mode_ctrl[port_c_d_pkg::SCK_SEL_LSB +: 2] = clock_select_field;
      serial_mode_ctrl[port_c_d_pkg::SM_LSB +: 2]      = serial_mode_field;
      serial_mode_ctrl[port_c_d_pkg::READY_EN_BIT]     = ready_enable_bit;
   end

   // Clock pin belongs to the serial block while any transfer mode is on
   assign serial_clock_on = serial_mode_field != 2'h0;
   assign clock_external  = clock_select_field == port_c_d_pkg::SCK_EXTERNAL;

   // Alternate function table, port C in the low indices
   always_comb begin
      alt_en  = '0;
      alt_out = '0;
      alt_oe  = '0;
      alt_en[port_c_d_pkg::PC_SERIAL_OUT_PIN_PIN]  = serial_mode_field[0];
      alt_out[port_c_d_pkg::PC_SERIAL_OUT_PIN_PIN] = ser_i.serial_out_pin;
      alt_oe[port_c_d_pkg::PC_SERIAL_OUT_PIN_PIN]  = 1'b1;
      alt_en[port_c_d_pkg::PC_SIN_PIN]   = serial_mode_field[1];
      alt_en[port_c_d_pkg::PC_CLOCK_PIN] = serial_clock_on;
      alt_out[port_c_d_pkg::PC_CLOCK_PIN] = ser_i.sck_out;
      alt_oe[port_c_d_pkg::PC_CLOCK_PIN] = !clock_external;
      alt_en[port_c_d_pkg::PC_READY_PIN] = ready_enable_bit;
      alt_out[port_c_d_pkg::PC_READY_PIN] = ser_i.ready_out;
      alt_oe[port_c_d_pkg::PC_READY_PIN] = clock_external;
      // Interrupt pins are inputs whatever the direction bit says
      alt_en[NPINS-1:PC_WIDTH] = port_d_alt_select;
   end

   assign gpio_out = {port_d_data, port_c_data};
   assign gpio_dir = {port_d_direction, port_c_direction};

   // One selector per pin
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_pin
         pin_select u_sel (
            .gpio_out_i (gpio_out[gi]),
            .gpio_dir_i (gpio_dir[gi]),
            .alt_en_i   (alt_en[gi]),
            .alt_out_i  (alt_out[gi]),
            .alt_oe_i   (alt_oe[gi]),
            .pin_out_o  (next_pin_out[gi]),
            .pin_oe_o   (next_pin_oe[gi])
         );
      end
   endgenerate

   // Registered pin drivers
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pc_out_o <= '0;
         pc_oe_o  <= '0;
         pd_out_o <= '0;
         pd_oe_o  <= '0;
      end else begin
         pc_out_o <= next_pin_out[PC_WIDTH-1:0];
         pc_oe_o  <= next_pin_oe[PC_WIDTH-1:0];
         pd_out_o <= next_pin_out[NPINS-1:PC_WIDTH];
         pd_oe_o  <= next_pin_oe[NPINS-1:PC_WIDTH];
      end
   end

   // Pin levels routed to the serial and interrupt logic, gated off
   // while the pin is not given to them
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ser_o     <= '0;
         ext_int_o <= '0;
      end else begin
         ser_o.serial_in_pin <= serial_mode_field[1] &&
                      pc_in_i[port_c_d_pkg::PC_SIN_PIN];
         ser_o.sck_in <= serial_clock_on && clock_external &&
                         pc_in_i[port_c_d_pkg::PC_CLOCK_PIN];
         ser_o.ready_in <= ready_enable_bit && !clock_external &&
                           pc_in_i[port_c_d_pkg::PC_READY_PIN];
         ext_int_o <= pd_in_i & port_d_alt_select;
      end
   end

   // Read multiplexer; data registers show the pins, not the latch
   always_comb begin
      next_rdata = port_c_d_pkg::READ_ZERO;
      case (bus_i.addr)
         port_c_d_pkg::PORT_C_DATA_ADDR: begin
            next_rdata[PC_LSB +: PC_WIDTH] = pc_in_i;
         end
         port_c_d_pkg::PORT_C_DIRECTION_ADDR: begin
            next_rdata[PC_LSB +: PC_WIDTH] = port_c_direction;
         end
         port_c_d_pkg::PORT_D_DATA_ADDR: begin
            next_rdata[PD_WIDTH-1:0] = pd_in_i;
         end
         port_c_d_pkg::PORT_D_DIRECTION_ADDR: begin
            next_rdata[PD_WIDTH-1:0] = port_d_direction;
         end
         port_c_d_pkg::PORT_D_ALT_SELECT_ADDR: begin
            next_rdata[PD_WIDTH-1:0] = port_d_alt_select;
         end
         port_c_d_pkg::SERIAL_MODE_CTRL_ADDR: begin
            next_rdata = serial_mode_ctrl;
         end
         default: begin
            next_rdata = port_c_d_pkg::READ_ZERO;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
      end else if (bus_i.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= '0;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_pc_dir_write: assert property (
      wr_c_dir |=> port_c_direction == $past(bus_i.wdata[6:3])
   ) else $error("port C direction write not stored");

   a_smode_write: assert property (
      wr_smode |=> serial_mode_ctrl[4:0] == $past(bus_i.wdata[4:0])
   ) else $error("serial mode control write not stored");

   a_latch_write: assert property (
      wr_c_data |=> port_c_data == $past(bus_i.wdata[6:3])
   ) else $error("port C latch write not stored");

   a_pd_dir_write: assert property (
      wr_d_dir |=> port_d_direction == $past(bus_i.wdata[2:0])
   ) else $error("port D direction write not stored");

   a_alt_write: assert property (
      wr_d_alt |=> port_d_alt_select == $past(bus_i.wdata[2:0])
   ) else $error("port D alternate select write not stored");

   a_rdata_idle: assert property (
      !bus_i.rd |=> rdata_o == port_c_d_pkg::READ_ZERO
   ) else $error("read data outside the read cycle");

   a_serial_out_pin_drive: assert property (
      serial_mode_field[0] |=> pc_oe_o[3] && pc_out_o[3] == $past(ser_i.serial_out_pin)
   ) else $error("serial data out not on pin");

   a_sin_input: assert property (
      serial_mode_field[1] |=> !pc_oe_o[2] && ser_o.serial_in_pin == $past(pc_in_i[2])
   ) else $error("serial data in pin not an input");

   a_sck_out: assert property (
      serial_clock_on && !clock_external
      |=> pc_oe_o[1] && pc_out_o[1] == $past(ser_i.sck_out)
   ) else $error("serial clock not driven out");

   a_sck_in: assert property (
      serial_clock_on && clock_external
      |=> !pc_oe_o[1] && ser_o.sck_in == $past(pc_in_i[1])
   ) else $error("external serial clock not taken");

   a_ready_in: assert property (
      ready_enable_bit && !clock_external
      |=> !pc_oe_o[0] && ser_o.ready_in == $past(pc_in_i[0])
   ) else $error("ready input not routed");

   a_ready_out: assert property (
      ready_enable_bit && clock_external
      |=> pc_oe_o[0] && pc_out_o[0] == $past(ser_i.ready_out)
   ) else $error("ready output not driven");

   a_int_input: assert property (
      port_d_alt_select[0] |=> !pd_oe_o[0] && ext_int_o[0] == $past(pd_in_i[0])
   ) else $error("interrupt pin driven or not routed");

   a_gpio_dir: assert property (
      !ready_enable_bit ##1 !ready_enable_bit
      |-> pc_oe_o[0] == $past(port_c_direction[0]) &&
          pc_out_o[0] == $past(port_c_data[0])
   ) else $error("plain port pin ignores latch or direction");

   a_read_pins: assert property (
      bus_i.rd && bus_i.addr == port_c_d_pkg::PORT_C_DATA_ADDR
      |=> rdata_o == {1'b0, $past(pc_in_i), 3'b000}
   ) else $error("port C data read not pin levels");

   a_alt_detach: assert property (
      port_d_alt_select == 3'h7 |=> pd_oe_o == 3'h0 && pd_out_o == 3'h0
   ) else $error("alternate pins still driven by latch");

   c_master_clock: cover property (
      serial_mode_field == 2'h3 && !clock_external && ready_enable_bit
   );
   c_slave_ready: cover property (
      serial_clock_on && clock_external && ready_enable_bit ##1 pc_oe_o[0]
   );
   c_int_pin: cover property (port_d_alt_select != 3'h0 ##1 ext_int_o != 3'h0);
   c_ext_clock: cover property (
      serial_clock_on && clock_external ##1 !pc_oe_o[1]
   );
   c_pin_read: cover property (
      bus_i.rd && bus_i.addr == port_c_d_pkg::PORT_D_DATA_ADDR
   );

endmodule

/* hw/port_c_d_pkg.sv */
// Package for the port C / port D pin multiplexer
package port_c_d_pkg;

   // Register offsets
   localparam logic [7:0] PORT_C_DATA_ADDR       = 8'hC4;
   localparam logic [7:0] PORT_C_DIRECTION_ADDR  = 8'hC5;
   localparam logic [7:0] PORT_D_DATA_ADDR       = 8'hC6;
   localparam logic [7:0] PORT_D_DIRECTION_ADDR  = 8'hC7;
   localparam logic [7:0] PORT_D_ALT_SELECT_ADDR = 8'hCD;
   localparam logic [7:0] SERIAL_MODE_CTRL_ADDR  = 8'hE0;

   // Port widths and placement of the port C pins inside their registers
   localparam int PC_WIDTH = 4;
   localparam int PC_LSB   = 3;
   localparam int PD_WIDTH = 3;

   // Port C pin index (0 = register bit 3)
   localparam int PC_READY_PIN = 0;
   localparam int PC_CLOCK_PIN = 1;
   localparam int PC_SIN_PIN   = 2;
   localparam int PC_SERIAL_OUT_PIN_PIN  = 3;

   // Serial mode control fields
   localparam int SCK_SEL_LSB  = 0;
   localparam int SM_LSB       = 2;
   localparam int READY_EN_BIT = 4;
   localparam logic [1:0] SCK_EXTERNAL = 2'h3;

   // Reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   // From the serial shifter towards the pins
   typedef struct packed {
      logic serial_out_pin;
      logic sck_out;
      logic ready_out;
   } ser_drive_s;

   // From the pins towards the serial shifter
   typedef struct packed {
      logic serial_in_pin;
      logic sck_in;
      logic ready_in;
   } ser_sense_s;

endpackage

/* hw/pin_select.sv */
// Per-pin choice between port latch and alternate function
`timescale 1ns/1ps
module pin_select (
   // Port latch side
   input  wire logic gpio_out_i,
   input  wire logic gpio_dir_i,
   // Alternate function side
   input  wire logic alt_en_i,
   input  wire logic alt_out_i,
   input  wire logic alt_oe_i,
   // Pin side
   output logic      pin_out_o,
   output logic      pin_oe_o
);

   // Alternate function detaches the latch and direction bit
   always_comb begin
      if (alt_en_i) begin
         pin_out_o = alt_out_i;
         pin_oe_o  = alt_oe_i;
      end else begin
         pin_out_o = gpio_out_i;
         pin_oe_o  = gpio_dir_i;
      end
   end

endmodule

/* sim/pin_partner.sv */
// Far-side pin model: outside drivers meeting the block's pin drivers
`timescale 1ns/1ps
module pin_partner #(
   parameter int W = 4
) (
   // Block side
   input  wire logic [W-1:0] out_i,
   input  wire logic [W-1:0] oe_i,
   // Outside world level
   input  wire logic [W-1:0] ext_i,
   // Resolved pin level
   output logic      [W-1:0] pin_o
);
   // Outside drivers yield wherever the block drives the pin
   assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

/* sim/tb.sv */
// Self-checking bench for the port C / port D pin multiplexer
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("FAIL %0t got %h want %h", $time, (got), (exp)); \
   end \
end
module tb;
   logic                     sys_clk_i = 1'b0;
   logic                     resetn_i;
   port_c_d_pkg::reg_req_s   bus;
   logic [7:0]               rdata_o;
   logic [3:0]               pc_in_i;
   logic [3:0]               pc_out_o;
   logic [3:0]               pc_oe_o;
   logic [2:0]               pd_in_i;
   logic [2:0]               pd_out_o;
   logic [2:0]               pd_oe_o;
   port_c_d_pkg::ser_drive_s ser;
   port_c_d_pkg::ser_sense_s ser_o;
   logic [2:0]               ext_int_o;
   logic [3:0]               ext_c;
   logic [2:0]               ext_d;
   logic [7:0]               r_dir_c, r_dat_c, r_dir_d, r_dat_d, r_alt, r_smc;
   logic [3:0]               e_oe, e_out, e_pin;
   logic [2:0]               e_oe_d, e_pin_d;
   port_c_d_pkg::ser_sense_s e_sense;
   logic [31:0]              seed = 32'h1906;
   logic [31:0]              v;
   int                       bad_count = 0;
   int                       checks_done = 0;

   always #5 sys_clk_i = ~sys_clk_i;

   port_c_d_pin_mux i_port_c_d_pin_mux (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_i(bus),
      .rdata_o(rdata_o), .pc_in_i(pc_in_i), .pc_out_o(pc_out_o),
      .pc_oe_o(pc_oe_o), .pd_in_i(pd_in_i), .pd_out_o(pd_out_o),
      .pd_oe_o(pd_oe_o), .ser_i(ser), .ser_o(ser_o), .ext_int_o(ext_int_o)
   );
   pin_partner #(.W(4)) i_pin_partner_c (
      .out_i(pc_out_o), .oe_i(pc_oe_o), .ext_i(ext_c), .pin_o(pc_in_i)
   );
   pin_partner #(.W(3)) i_pin_partner_d (
      .out_i(pd_out_o), .oe_i(pd_oe_o), .ext_i(ext_d), .pin_o(pd_in_i)
   );

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected pin drive, pin levels and shifter inputs from register state
   function automatic void calc();
      logic [1:0] sm;
      logic       ext_sck;
      sm = r_smc[3:2];
      ext_sck = (r_smc[1:0] == port_c_d_pkg::SCK_EXTERNAL);
      e_oe = r_dir_c[6:3];
      e_out = r_dat_c[6:3];
      if (sm[0]) begin
         e_oe[3] = 1'b1;
         e_out[3] = ser.serial_out_pin;
      end
      if (sm[1]) begin
         e_oe[2] = 1'b0;
      end
      if (sm != 2'h0) begin
         e_oe[1] = !ext_sck;
         e_out[1] = ser.sck_out;
      end
      if (r_smc[4]) begin
         e_oe[0] = ext_sck;
         e_out[0] = ser.ready_out;
      end
      e_pin = (e_oe & e_out) | (~e_oe & ext_c);
      e_sense.serial_in_pin = sm[1] & e_pin[2];
      e_sense.sck_in = (sm != 2'h0) & ext_sck & e_pin[1];
      e_sense.ready_in = r_smc[4] & !ext_sck & e_pin[0];
      e_oe_d = r_dir_d[2:0] & ~r_alt[2:0];
      e_pin_d = (e_oe_d & r_dat_d[2:0]) | (~e_oe_d & ext_d);
   endfunction

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge sys_clk_i);
      bus.wr <= 1'b0;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge sys_clk_i);
      bus.rd <= 1'b0;
      @(negedge sys_clk_i);
      `CHK(rdata_o, exp)
   endtask

   task automatic check_all();
      repeat (4) @(posedge sys_clk_i);
      calc();
      @(negedge sys_clk_i);
      `CHK(pc_oe_o, e_oe)
      `CHK(pc_oe_o[3], e_oe[3])
      `CHK(pc_oe_o[1], e_oe[1])
      `CHK(pc_oe_o[0], e_oe[0])
      `CHK(pc_out_o & e_oe, e_out & e_oe)
      `CHK(ser_o, e_sense)
      `CHK(pd_oe_o, e_oe_d)
      `CHK(pd_out_o & e_oe_d, r_dat_d[2:0] & e_oe_d)
      `CHK(ext_int_o, e_pin_d & r_alt[2:0])
      chk_rd(8'hC4, {1'b0, e_pin, 3'h0});
      chk_rd(8'hC5, {1'b0, r_dir_c[6:3], 3'h0});
      chk_rd(8'hC6, {5'h0, e_pin_d});
      chk_rd(8'hC7, {5'h0, r_dir_d[2:0]});
      chk_rd(8'hCD, {5'h0, r_alt[2:0]});
      chk_rd(8'hE0, {3'h0, r_smc[4:0]});
      chk_rd(8'hC8, 8'h00);
   endtask

   task automatic stop_test();
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      bad_count++;
      stop_test();
   end

   initial begin
      resetn_i = 1'b0;
      bus = '0;
      ser = '0;
      ext_c = 4'hA;
      ext_d = 3'h5;
      {r_dir_c, r_dat_c, r_dir_d, r_dat_d, r_alt, r_smc} = '0;
      repeat (2) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      check_all();
      // All 32 control codes first, then random control bytes
      for (int i = 0; i < 64; i++) begin
         v = rnd();
         r_smc = (i < 32) ? 8'(i) : v[7:0];
         r_dir_c = v[15:8];
         r_dat_c = v[23:16];
         r_alt = v[31:24];
         v = rnd();
         r_dir_d = v[7:0];
         r_dat_d = v[15:8];
         @(posedge sys_clk_i);
         ext_c <= v[19:16];
         ext_d <= v[22:20];
         ser <= v[25:23];
         wr_reg(8'hE0, r_smc);
         wr_reg(8'hC5, r_dir_c);
         wr_reg(8'hC4, r_dat_c);
         wr_reg(8'hCD, r_alt);
         wr_reg(8'hC7, r_dir_d);
         wr_reg(8'hC6, r_dat_d);
         wr_reg(8'hC8, v[31:24]);
         check_all();
      end
      // Reset in mid-run returns every pin to plain input
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      {r_dir_c, r_dat_c, r_dir_d, r_dat_d, r_alt, r_smc} = '0;
      repeat (2) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      check_all();
      stop_test();
   end
endmodule
